// [xcvr_mode_cfg.svh]
`ifndef XCVR_MODE_CFG_SVH
`define XCVR_MODE_CFG_SVH

// Clock rate and timing figures
`define MCLK_MHZ          125
`define CYCLES_PER_MS     (`MCLK_MHZ * 1000)
`define LINK_OFF_MIN_MS   100
`define FLASH_MIN_MS      20
`define TIMER_W           24

// Register map, byte addresses
`define ADDR_CTRL         32'h0000_0000
`define ADDR_STATUS       32'h0000_0004

// Control fields
`define CTRL_STRETCH_BIT  0
`define CTRL_RESET        1'h1

// Bus encodings
`define HTRANS_NONSEQ_BIT 1
`define HRESP_OKAY        1'h0

`endif

// [xcvr_mode_pkg.sv]
package xcvr_mode_pkg;

    typedef struct packed {
        logic auto_port_select;
        logic polarity_squelch_option;
        logic polarity_squelch_float;
        logic link_check_disable;
        logic controller_variant_sel0;
        logic controller_variant_sel1;
        logic loopback_n;
        logic jabber_disable;
        logic test_enable;
        logic device_reset;
        logic collision_pin_in;
        logic port_select_in;
    } mode_pins_t;

    typedef struct packed {
        logic tx_active;
        logic rx_active;
        logic collision_active;
        logic link_good;
        logic tp_frame_valid;
        logic polarity_reversed;
    } line_status_t;

    typedef struct packed {
        logic transmit_indicator;
        logic receive_indicator;
        logic collision_indicator;
        logic link_indicator;
        logic polarity_fault_indicator;
    } indicators_t;

    typedef struct packed {
        logic core_reset;
        logic tp_port_active;
        logic auto_polarity_fix;
        logic extended_squelch;
        logic link_check_enable;
        logic jabber_enable;
        logic loopback_active;
        logic clk_cdt_sense_high;
        logic rts_crs_sense_high;
        logic low_power;
        logic test_mode;
        logic test_variant;
    } mode_out_t;

    typedef enum logic [1:0] {
        ST_RESET,
        ST_NORMAL,
        ST_LOW_POWER,
        ST_TEST
    } op_state_t;

endpackage : xcvr_mode_pkg

// [xcvr_mode_ctrl.sv]
// Our own choices: the address map and the AHB-Lite register port.
`timescale 1ns/1ps
`include "xcvr_mode_cfg.svh"
// Operation
// (RULE1) Manual port mode: port pin is an input, high picks twisted pair, low AUI.
// (RULE2) Automatic port mode: drive port pin, high for twisted pair, low for AUI.
// (RULE3) Automatic mode picks twisted pair when link beats or frames are seen.
// (RULE4) Polarity option high: extended squelch off, automatic polarity fix on.
// (RULE5) Option floating: both functions on; option low: both off.
// (RULE6) Polarity fault shown on its indicator whatever the fix setting.
// (RULE7) Link check disable high turns link integrity off, low turns it on.
// (RULE8) Two select inputs decode into four controller interface variants.
// (RULE9) Clocks and collision active low for 0/0, 0/1; RTS, CARRIER_SENSE_OUT low for 0/0.
// (RULE10) Loopback input low isolates the medium; floating input reads high.
// (RULE11) Loopback leaves link check, link beats and port choice running.
// (RULE12) Jabber disable high turns jabber protection off, low protects active port.
// (RULE13) Jabber disable and test at reset fall: low power until either drops.
// (RULE14) Test high with reset released enters customer test mode; low keeps it off.
// (RULE15) Reset pin high holds the core in reset; modes chosen at its fall.
// (RULE16) Transmit indicator rests high, lights on transmit, flashes with activity.
// (RULE17) Receive indicator rests high, lights on receive, flashes with activity.
// (RULE18) Collision indicator lights on collisions; its pin picks the test variant.
// (RULE19) Link indicator on with good or disabled link in TP, off in AUI or failure.
// (RULE20) Link indicator stays off at least 100 ms once it turns off.
// (RULE21) Polarity indicator lights on reversal and stays on after correction.
// (RULE22) A 10 MHz clock is made by dividing the base clock by two; here mclk is 125 MHz, so clk_div2 runs at 62.5 MHz.
// (RULE23) All mode and strap inputs pass two flip-flops before use.
// (RULE24) Activity flashes are stretched to a visible minimum length.
module xcvr_mode_ctrl #(
    parameter int unsigned LINK_OFF_CYCLES = `LINK_OFF_MIN_MS * `CYCLES_PER_MS,
    parameter int unsigned FLASH_CYCLES    = `FLASH_MIN_MS * `CYCLES_PER_MS
) (
    input  wire logic                       mclk,
    input  wire logic                       rst_n,
    input  wire logic                       hsel,
    input  wire logic [31:0]                haddr,
    input  wire logic [1:0]                 htrans,
    input  wire logic                       hwrite,
    input  wire logic [2:0]                 hsize,
    input  wire logic [31:0]                hwdata,
    input  wire logic                       hready,
    output logic      [31:0]                hrdata,
    output logic                            hreadyout,
    output logic                            hresp,
    input  wire xcvr_mode_pkg::mode_pins_t   mode_pins,
    input  wire xcvr_mode_pkg::line_status_t line_status,
    output logic                            port_select_out,
    output logic                            port_select_oe,
    output logic                            clk_div2,
    output xcvr_mode_pkg::mode_out_t         mode_out,
    output xcvr_mode_pkg::indicators_t       indicators
);

    localparam int W_MODE = $bits(xcvr_mode_pkg::mode_pins_t);
    localparam int W_LINE = $bits(xcvr_mode_pkg::line_status_t);
    localparam int W_SYNC = W_MODE + W_LINE;
    localparam int N_ACT  = 3;

    // Reset value keeps the core in reset and loopback idle until real samples arrive
    localparam xcvr_mode_pkg::mode_pins_t MODE_RST = '{
        device_reset: 1'h1, loopback_n: 1'h1, default: 1'h0};
    localparam logic [W_SYNC-1:0] SYNC_RST = {MODE_RST, {W_LINE{1'h0}}};

    localparam logic [`TIMER_W-1:0] LINK_OFF_LOAD = `TIMER_W'(LINK_OFF_CYCLES);
    localparam logic [`TIMER_W-1:0] FLASH_HALF    = `TIMER_W'(FLASH_CYCLES);
    localparam logic [`TIMER_W-1:0] FLASH_LOAD    = `TIMER_W'(2 * FLASH_CYCLES);

    xcvr_mode_pkg::mode_pins_t   m;
    xcvr_mode_pkg::line_status_t s;

    logic [W_SYNC-1:0] sync1_q;
    logic [W_SYNC-1:0] sync2_q;

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            sync1_q <= SYNC_RST;
            sync2_q <= SYNC_RST;
        end else begin
            sync1_q <= {mode_pins, line_status}; // [RULE23]
            sync2_q <= sync1_q;                  // [RULE23]
        end
    end

    assign {m, s} = sync2_q;

    // Operating state and mode decode
    xcvr_mode_pkg::op_state_t state_q;
    xcvr_mode_pkg::op_state_t state_d;
    logic                     variant_q;
    logic                     variant_d;
    xcvr_mode_pkg::mode_out_t mode_q;
    xcvr_mode_pkg::mode_out_t mode_d;
    logic                     ps_out_q;
    logic                     ps_out_d;
    logic                     ps_oe_q;
    logic                     ps_oe_d;
    logic                     div_q;
    logic                     div_d;

    always_comb begin
        state_d   = state_q;
        variant_d = variant_q;
        case (state_q)
            xcvr_mode_pkg::ST_RESET: begin
                // First cycle with reset low is the falling edge
                if (!m.device_reset) begin
                    variant_d = m.collision_pin_in; // [RULE18]
                    if (m.jabber_disable && m.test_enable) begin
                        state_d = xcvr_mode_pkg::ST_LOW_POWER; // [RULE13]
                    end else if (m.test_enable) begin
                        state_d = xcvr_mode_pkg::ST_TEST; // [RULE14]
                    end else begin
                        state_d = xcvr_mode_pkg::ST_NORMAL;
                    end
                end
            end
            xcvr_mode_pkg::ST_LOW_POWER: begin
                if (!m.jabber_disable || !m.test_enable) begin
                    state_d = xcvr_mode_pkg::ST_NORMAL; // [RULE13]
                end
            end
            xcvr_mode_pkg::ST_TEST: begin
                if (!m.test_enable) begin
                    state_d = xcvr_mode_pkg::ST_NORMAL; // [RULE14]
                end
            end
            xcvr_mode_pkg::ST_NORMAL: begin
                if (m.test_enable) begin
                    state_d = xcvr_mode_pkg::ST_TEST; // [RULE14]
                end
            end
            default: begin
                state_d = xcvr_mode_pkg::ST_RESET;
            end
        endcase
        if (m.device_reset) begin
            state_d = xcvr_mode_pkg::ST_RESET; // [RULE15]
        end

        mode_d            = '0;
        mode_d.core_reset = m.device_reset; // [RULE15]
        // Port choice ignores loopback so isolation never disturbs it
        if (m.auto_port_select) begin
            mode_d.tp_port_active = s.link_good | s.tp_frame_valid; // [RULE3] [RULE11]
        end else begin
            mode_d.tp_port_active = m.port_select_in; // [RULE1]
        end
        // A floating option pin enables both regardless of the sampled level
        mode_d.extended_squelch   = m.polarity_squelch_float;                  // [RULE4] [RULE5]
        mode_d.auto_polarity_fix  = m.polarity_squelch_float
                                  | m.polarity_squelch_option;                 // [RULE4] [RULE5]
        mode_d.link_check_enable  = ~m.link_check_disable;                     // [RULE7] [RULE11]
        mode_d.jabber_enable      = ~m.jabber_disable;                         // [RULE12]
        mode_d.loopback_active    = ~m.loopback_n;                             // [RULE10]
        mode_d.clk_cdt_sense_high = m.controller_variant_sel0;                 // [RULE8] [RULE9]
        mode_d.rts_crs_sense_high = m.controller_variant_sel0
                                  | m.controller_variant_sel1;                 // [RULE8] [RULE9]
        mode_d.low_power          = (state_d == xcvr_mode_pkg::ST_LOW_POWER);
        mode_d.test_mode          = (state_d == xcvr_mode_pkg::ST_TEST);
        mode_d.test_variant       = variant_d;
        if (m.device_reset) begin
            mode_d.tp_port_active = 1'h0;
        end

        ps_oe_d  = m.auto_port_select & ~m.device_reset; // [RULE1] [RULE2]
        ps_out_d = mode_d.tp_port_active;                // [RULE2]
        div_d    = ~div_q;                               // [RULE22]
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            state_q   <= xcvr_mode_pkg::ST_RESET;
            variant_q <= 1'h0;
            mode_q    <= '0;
            ps_out_q  <= 1'h0;
            ps_oe_q   <= 1'h0;
            div_q     <= 1'h0;
        end else begin
            state_q   <= state_d;
            variant_q <= variant_d;
            mode_q    <= mode_d;
            ps_out_q  <= ps_out_d;
            ps_oe_q   <= ps_oe_d;
            div_q     <= div_d;
        end
    end

    // Indicators, all active low
    logic                  stretch_en_q;
    logic [`TIMER_W-1:0]   flash_q [N_ACT];
    logic [`TIMER_W-1:0]   flash_d [N_ACT];
    logic [N_ACT-1:0]      act_on_d;
    logic [N_ACT-1:0]      act;
    logic [`TIMER_W-1:0]   link_cnt_q;
    logic [`TIMER_W-1:0]   link_cnt_d;
    logic                  link_want;
    logic                  pol_seen_q;
    logic                  pol_seen_d;
    xcvr_mode_pkg::indicators_t ind_q;
    xcvr_mode_pkg::indicators_t ind_d;

    assign act = {s.tx_active, s.rx_active, s.collision_active};

    always_comb begin
        // Each flash is one lit half and one dark half, so steady traffic blinks
        for (int i = 0; i < N_ACT; i++) begin
            flash_d[i] = flash_q[i];
            if (flash_q[i] != '0) begin
                flash_d[i] = flash_q[i] - `TIMER_W'(1);
            end else if (act[i]) begin
                flash_d[i] = FLASH_LOAD; // [RULE24]
            end
            act_on_d[i] = stretch_en_q ? (flash_d[i] > FLASH_HALF) : act[i]; // [RULE24]
            if (m.device_reset) begin
                flash_d[i]  = '0;
                act_on_d[i] = 1'h0;
            end
        end

        link_want  = mode_d.tp_port_active
                   & (s.link_good | ~mode_d.link_check_enable); // [RULE19]
        link_cnt_d = link_cnt_q;
        ind_d      = ind_q;
        ind_d.transmit_indicator  = ~act_on_d[2]; // [RULE16]
        ind_d.receive_indicator   = ~act_on_d[1]; // [RULE17]
        ind_d.collision_indicator = ~act_on_d[0]; // [RULE18]
        if (!ind_q.link_indicator) begin
            if (!link_want) begin
                ind_d.link_indicator = 1'h1;          // [RULE19]
                link_cnt_d           = LINK_OFF_LOAD; // [RULE20]
            end
        end else if (link_cnt_q != '0) begin
            link_cnt_d = link_cnt_q - `TIMER_W'(1);   // [RULE20]
        end else if (link_want) begin
            ind_d.link_indicator = 1'h0;              // [RULE19]
        end

        // Fault stays latched after the fix has compensated for it
        pol_seen_d = pol_seen_q | s.polarity_reversed;     // [RULE6] [RULE21]
        ind_d.polarity_fault_indicator = ~pol_seen_d;      // [RULE21]

        if (m.device_reset) begin
            link_cnt_d = '0;
            pol_seen_d = 1'h0;
            ind_d      = '1;
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            for (int i = 0; i < N_ACT; i++) begin
                flash_q[i] <= '0;
            end
            link_cnt_q <= '0;
            pol_seen_q <= 1'h0;
            ind_q      <= '1;
        end else begin
            for (int i = 0; i < N_ACT; i++) begin
                flash_q[i] <= flash_d[i];
            end
            link_cnt_q <= link_cnt_d;
            pol_seen_q <= pol_seen_d;
            ind_q      <= ind_d;
        end
    end

    // AHB-Lite slave, zero wait states
    logic        wr_pend_q;
    logic        wr_pend_d;
    logic [31:0] wr_addr_q;
    logic [31:0] wr_addr_d;
    logic [31:0] rdata_q;
    logic [31:0] rdata_d;
    logic        stretch_en_d;
    logic        addr_phase;
    logic        ready_q;
    logic        resp_q;

    assign addr_phase = hsel & htrans[`HTRANS_NONSEQ_BIT] & hready;

    always_comb begin
        wr_pend_d    = addr_phase & hwrite;
        wr_addr_d    = addr_phase ? haddr : wr_addr_q;
        stretch_en_d = stretch_en_q;
        rdata_d      = '0;
        if (wr_pend_q && wr_addr_q == `ADDR_CTRL) begin
            stretch_en_d = hwdata[`CTRL_STRETCH_BIT];
        end
        if (addr_phase && !hwrite) begin
            case (haddr)
                `ADDR_CTRL:   rdata_d = 32'(stretch_en_d);
                `ADDR_STATUS: rdata_d = 32'({state_q, mode_q, ind_q});
                default:      rdata_d = '0;
            endcase
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            wr_pend_q    <= 1'h0;
            wr_addr_q    <= '0;
            rdata_q      <= '0;
            stretch_en_q <= `CTRL_RESET;
            ready_q      <= 1'h1;
            resp_q       <= `HRESP_OKAY;
        end else begin
            wr_pend_q    <= wr_pend_d;
            wr_addr_q    <= wr_addr_d;
            rdata_q      <= rdata_d;
            stretch_en_q <= stretch_en_d;
            ready_q      <= 1'h1;
            resp_q       <= `HRESP_OKAY;
        end
    end

    assign hrdata          = rdata_q;
    assign hreadyout       = ready_q;
    assign hresp           = resp_q;
    assign port_select_out = ps_out_q;
    assign port_select_oe  = ps_oe_q;
    assign clk_div2        = div_q;
    assign mode_out        = mode_q;
    assign indicators      = ind_q;

    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!rst_n);

    property p_manual_port;
        !m.auto_port_select && !m.device_reset
        |=> port_select_oe == 1'h0 && mode_out.tp_port_active == $past(m.port_select_in);
    endproperty
    a_manual_port: assert property (p_manual_port) else $error("manual port choice wrong"); // [RULE1]
    property p_auto_drive;
        m.auto_port_select && !m.device_reset
        |=> port_select_oe && port_select_out == mode_out.tp_port_active;
    endproperty
    a_auto_drive: assert property (p_auto_drive) else $error("port pin not driven"); // [RULE2]
    property p_auto_choice;
        m.auto_port_select && !m.device_reset && !s.link_good && !s.tp_frame_valid
        |=> !mode_out.tp_port_active;
    endproperty
    a_auto_choice: assert property (p_auto_choice) else $error("auto port kept TP"); // [RULE3]
    property p_pol_high;
        !m.polarity_squelch_float && m.polarity_squelch_option && !m.device_reset
        |=> mode_out.auto_polarity_fix && !mode_out.extended_squelch;
    endproperty
    a_pol_high: assert property (p_pol_high) else $error("option high decode wrong"); // [RULE4]
    property p_pol_float;
        !m.device_reset ##0 (m.polarity_squelch_float || !m.polarity_squelch_option)
        |=> mode_out.auto_polarity_fix == mode_out.extended_squelch;
    endproperty
    a_pol_float: assert property (p_pol_float) else $error("option float or low decode wrong"); // [RULE5]
    property p_variant;
        !m.device_reset
        |=> mode_out.clk_cdt_sense_high == $past(m.controller_variant_sel0)
            && mode_out.rts_crs_sense_high
               == ($past(m.controller_variant_sel0) | $past(m.controller_variant_sel1));
    endproperty
    a_variant: assert property (p_variant) else $error("controller variant sense wrong"); // [RULE9]
    property p_lp_entry;
        state_q == xcvr_mode_pkg::ST_RESET && !m.device_reset && m.jabber_disable && m.test_enable
        |=> mode_out.low_power
            ##1 (mode_out.low_power || $past(m.device_reset) || !$past(m.jabber_disable && m.test_enable));
    endproperty
    a_lp_entry: assert property (p_lp_entry) else $error("low power not entered"); // [RULE13]
    property p_lp_exit;
        state_q == xcvr_mode_pkg::ST_LOW_POWER && !m.device_reset
        ##0 (!m.jabber_disable || !m.test_enable) |=> !mode_out.low_power;
    endproperty
    a_lp_exit: assert property (p_lp_exit) else $error("low power not left"); // [RULE13]
    property p_reset_hold;
        m.device_reset |=> state_q == xcvr_mode_pkg::ST_RESET && indicators == '1;
    endproperty
    a_reset_hold: assert property (p_reset_hold) else $error("core not held in reset"); // [RULE15]
    property p_tx_flash;
        s.tx_active && !m.device_reset && flash_q[2] == '0 |=> !indicators.transmit_indicator;
    endproperty
    a_tx_flash: assert property (p_tx_flash) else $error("transmit indicator not lit"); // [RULE16]
    property p_link_hold;
        link_cnt_q != '0 |-> indicators.link_indicator;
    endproperty
    a_link_hold: assert property (p_link_hold) else $error("link indicator on too soon"); // [RULE20]
    property p_pol_sticky;
        !indicators.polarity_fault_indicator && !m.device_reset
        |=> !indicators.polarity_fault_indicator;
    endproperty
    a_pol_sticky: assert property (p_pol_sticky) else $error("polarity indicator dropped"); // [RULE21]
    property p_clk_div;
        clk_div2 |=> !clk_div2 ##1 clk_div2;
    endproperty
    a_clk_div: assert property (p_clk_div) else $error("divided clock not toggling"); // [RULE22]

endmodule : xcvr_mode_ctrl

// [strap_line_model.sv]
`timescale 1ns/1ps
module strap_line_model (
    input  wire xcvr_mode_pkg::mode_pins_t  want,
    input  wire xcvr_mode_pkg::indicators_t indicators,
    input  wire logic                       port_select_out,
    input  wire logic                       port_select_oe,
    output xcvr_mode_pkg::mode_pins_t       pins
);
    always_comb begin
        pins = want;
        // Strap resistor loses to the device whenever the device drives the pin
        pins.port_select_in = port_select_oe ? port_select_out : want.port_select_in;
        // LED pin idles high through its pull-up, so it reads back the lamp level
        pins.collision_pin_in = indicators.collision_indicator;
    end
endmodule : strap_line_model

// [tb_xcvr_mode_ctrl.sv]
`timescale 1ns/1ps
`include "xcvr_mode_cfg.svh"
module tb_xcvr_mode_ctrl;
    localparam int unsigned LOFF = 50;
    localparam int unsigned FL   = 10;
    logic                        mclk, rst_n, hsel, hwrite, hreadyout, hresp, c;
    logic                        port_select_out, port_select_oe, clk_div2;
    logic [31:0]                 haddr, hwdata, hrdata, rd;
    logic [1:0]                  htrans;
    logic [2:0]                  hsize;
    xcvr_mode_pkg::mode_pins_t   want, pins;
    xcvr_mode_pkg::line_status_t ls;
    xcvr_mode_pkg::mode_out_t    m;
    xcvr_mode_pkg::indicators_t  ind;
    int                          fails, checks;

    xcvr_mode_ctrl #(.LINK_OFF_CYCLES(LOFF), .FLASH_CYCLES(FL)) i_dut (
        .mclk(mclk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
        .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
        .hresp(hresp), .mode_pins(pins), .line_status(ls), .port_select_out(port_select_out),
        .port_select_oe(port_select_oe), .clk_div2(clk_div2), .mode_out(m), .indicators(ind)
    );
    strap_line_model i_far (
        .want(want), .indicators(ind), .port_select_out(port_select_out),
        .port_select_oe(port_select_oe), .pins(pins)
    );

    initial begin
        mclk = 1'b0;
        forever #4 mclk = ~mclk;
    end

    task automatic results();
        $display("checks %0d fails %0d", checks, fails);
        if (fails == 0 && checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : results

    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        checks++;
        if (s !== e) begin
            fails++;
            $display("wrong value at %0t: seen %h expected %h", $time, s, e);
        end
    endtask : chk

    task automatic at(input int n);
        repeat (n) @(negedge mclk);
    endtask : at

    // Bus signals are stable at the falling edge, so sampling there avoids edge races
    task automatic rdy(output logic [31:0] d);
        int   n;
        logic s;
        n = 0;
        do begin
            @(negedge mclk);
            s = hreadyout;
            d = hrdata;
            @(posedge mclk);
            n++;
        end while (s !== 1'b1 && n < 50);
        if (s !== 1'b1) begin
            fails++;
            results();
        end
    endtask : rdy

    task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] wd, output logic [31:0] d);
        @(posedge mclk);
        hsel   <= 1'h1;
        htrans <= 2'h2;
        haddr  <= a;
        hwrite <= wr;
        rdy(d);
        hsel   <= 1'h0;
        htrans <= 2'h0;
        hwdata <= wd;
        rdy(d);
    endtask : bus

    initial begin
        rst_n = 1'b0; hsel = 1'b0; haddr = '0; htrans = 2'h0; hwrite = 1'b0;
        hsize = 3'h2; hwdata = '0; fails = 0; checks = 0; ls = '0; want = '0;
        want.device_reset = 1'b1;
        want.loopback_n = 1'b1;
        repeat (10) @(posedge mclk);
        rst_n <= 1'b1;
        bus(1'b0, `ADDR_CTRL, 32'h0, rd); chk(rd, 32'h1);
        bus(1'b0, `ADDR_STATUS, 32'h0, rd); chk({rd[18:16], rd[4:0]}, {3'h1, 5'h1F});
        bus(1'b1, 32'h8, 32'hFFFF_FFFF, rd);
        bus(1'b0, 32'h8, 32'h0, rd); chk(rd, 32'h0);
        @(posedge mclk) want.device_reset <= 1'b0;
        at(5); chk({m.core_reset, m.test_mode, m.low_power, hresp}, 4'h0);
        bus(1'b0, `ADDR_STATUS, 32'h0, rd); chk(rd[18:17], 2'h1);
        at(1); c = clk_div2;
        at(1); chk(clk_div2, !c);
        for (int i = 0; i < 4; i++) begin
            @(posedge mclk);
            want.controller_variant_sel0 <= i[1];
            want.controller_variant_sel1 <= i[0];
            at(5); chk({m.clk_cdt_sense_high, m.rts_crs_sense_high}, {i[1], i[1] | i[0]});
        end
        for (int j = 0; j < 3; j++) begin
            @(posedge mclk);
            want.polarity_squelch_option <= (j == 0);
            want.polarity_squelch_float  <= (j == 1);
            at(5); chk({m.auto_polarity_fix, m.extended_squelch}, {j < 2, j == 1});
        end
        for (int k = 1; k >= 0; k--) begin
            @(posedge mclk);
            want.link_check_disable <= k[0];
            want.jabber_disable     <= k[0];
            want.loopback_n         <= k[0];
            at(5); chk({m.link_check_enable, m.jabber_enable, m.loopback_active}, {3{!k[0]}});
        end
        for (int p = 0; p < 2; p++) begin
            @(posedge mclk) want.port_select_in <= p[0];
            at(5); chk({port_select_oe, m.tp_port_active}, {1'b0, p[0]});
        end
        @(posedge mclk) want.auto_port_select <= 1'b1;
        for (int p = 0; p < 2; p++) begin
            @(posedge mclk) ls.link_good <= p[0];
            at(5); chk({port_select_oe, port_select_out, m.tp_port_active}, {1'b1, p[0], p[0]});
        end
        chk(ind.link_indicator, 1'b0);
        @(posedge mclk) ls.link_good <= 1'b0;
        @(posedge mclk) ls.link_good <= 1'b1;
        at(LOFF - 8); chk(ind.link_indicator, 1'b1);
        at(14); chk(ind.link_indicator, 1'b0);
        @(posedge mclk);
        ls.tp_frame_valid <= 1'b1;
        ls.link_good <= 1'b0;
        want.link_check_disable <= 1'b1;
        at(5); chk(ind.link_indicator, 1'b0);
        @(posedge mclk) ls.tp_frame_valid <= 1'b0;
        at(5); chk(ind.link_indicator, 1'b1);
        @(posedge mclk) ls.polarity_reversed <= 1'b1;
        at(5); chk(ind.polarity_fault_indicator, 1'b0);
        @(posedge mclk) ls.polarity_reversed <= 1'b0;
        at(5); chk(ind.polarity_fault_indicator, 1'b0);
        for (int b = 0; b < 3; b++) begin
            @(posedge mclk) ls[5-b] <= 1'b1;
            @(posedge mclk) ls[5-b] <= 1'b0;
            at(4); chk(ind[4-b], 1'b0);
            at(FL + 6); chk(ind[4-b], 1'b1);
            at(FL + 6);
        end
        // With stretching off the indicator follows activity three cycles late
        bus(1'b1, `ADDR_CTRL, 32'h0, rd);
        bus(1'b0, `ADDR_CTRL, 32'h0, rd); chk(rd, 32'h0);
        @(posedge mclk) ls.tx_active <= 1'b1;
        @(posedge mclk) ls.tx_active <= 1'b0;
        at(3); chk(ind.transmit_indicator, 1'b0);
        at(1); chk(ind.transmit_indicator, 1'b1);
        @(posedge mclk);
        want.device_reset <= 1'b1;
        want.jabber_disable <= 1'b1;
        want.test_enable <= 1'b1;
        at(5); chk({m.core_reset, ind.polarity_fault_indicator}, 2'h3);
        @(posedge mclk) want.device_reset <= 1'b0;
        at(5); chk({m.low_power, m.test_variant}, 2'h3);
        bus(1'b0, `ADDR_STATUS, 32'h0, rd); chk(rd[18:17], 2'h2);
        @(posedge mclk) want.jabber_disable <= 1'b0;
        at(5); chk({m.low_power, m.test_mode}, 2'h1);
        results();
    end
endmodule : tb_xcvr_mode_ctrl
